//--- rtl/assc_pkg.sv
// Constants, types and helpers shared by the sample sequencer control block
package assc_pkg;
    // ==========================================
    // Sizes
    localparam int NSEQ = 4;
    localparam int NTRIG = 4;
    localparam int RES_W = 10;
    // ==========================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_ACT = 8'h00;
    localparam logic [7:0] OFF_RIS = 8'h04;
    localparam logic [7:0] OFF_IM = 8'h08;
    localparam logic [7:0] OFF_ISC = 8'h0C;
    localparam logic [7:0] OFF_OVF = 8'h10;
    localparam logic [7:0] OFF_TRG = 8'h14;
    localparam logic [7:0] OFF_UDF = 8'h18;
    localparam logic [7:0] OFF_PRI = 8'h1C;
    localparam logic [7:0] OFF_PSI = 8'h20;
    localparam logic [7:0] OFF_AVG = 8'h24;
    // Sequencer n window at 0x80 + 0x20*n
    localparam logic [4:0] SUB_MUX = 5'h00;
    localparam logic [4:0] SUB_CTL = 5'h04;
    localparam logic [4:0] SUB_FIFO = 5'h08;
    localparam logic [4:0] SUB_FST = 5'h0C;
    // ==========================================
    // Field positions and reset values
    localparam int CB_DIFF = 0;
    localparam int CB_END = 1;
    localparam int CB_IE = 2;
    localparam int CB_TEMP = 3;
    localparam int FST_EMPTY = 8;
    localparam int FST_FULL = 12;
    localparam logic [15:0] PRIO_RST = 16'h3210;
    localparam logic [3:0] TRG_PROC = 4'h0;
    localparam logic [3:0] TRG_ALWAYS = 4'hF;
    localparam logic [2:0] AVG_MAX = 3'h6;
    // ==========================================
    // Timing: one sample slot at 500 ksps
    localparam int SAMPLE_NS = 2000;
    localparam int CLK_NS = 40;
    localparam int PACE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
    // ==========================================
    // Types
    typedef enum logic [1:0] {PH_IDLE, PH_ISSUE, PH_WAIT} assc_phase_t;
    typedef struct packed {
        logic start;
        logic temp;
        logic diff;
        logic [2:0] sel;
    } assc_conv_req_t;
    typedef struct packed {
        logic [3:0] act, ris, im, ovf, udf, pend;
        logic [15:0] trg, pri;
        logic [2:0] avg;
        logic [3:0][31:0] mux, ctl;
        logic [3:0][7:0][9:0] fifo;
        logic [3:0][2:0] head, tail;
        logic [3:0][3:0] cnt;
        assc_phase_t ph;
        logic [1:0] cur;
        logic [2:0] step;
        logic [5:0] nsmp;
        logic [15:0] acc;
        logic [5:0] pace;
        logic [3:0] ts1, ts2, ts3, tstab;
        logic ack;
        logic [31:0] dat;
        assc_conv_req_t conv;
    } assc_state_t;
    // ==========================================
    // Per-sequencer capacity: 8, 4, 4, 1
    function automatic int seq_depth(input logic [1:0] s);
        case (s)
            2'h0: return 8;
            2'h3: return 1;
            default: return 4;
        endcase
    endfunction
    function automatic logic [31:0] step_mask(input logic [1:0] s);
        case (s)
            2'h0: return 32'hFFFF_FFFF;
            2'h3: return 32'h0000_000F;
            default: return 32'h0000_FFFF;
        endcase
    endfunction
    function automatic logic [2:0] ptr_inc(input logic [2:0] p, input logic [1:0] s);
        return (int'(p) == seq_depth(s) - 1) ? 3'h0 : p + 3'h1;
    endfunction
endpackage

//--- rtl/assc_top.sv
// Sample sequencer control: Wishbone registers, arbitration, sequencing, result FIFOs
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// R1: Four sequencers; sequencer 0 has 8 steps/entries, 1 and 2 four, 3 one.
// R2: Each FIFO word is 32 bits, result in the low ten bits.
// R3: Each step has a 4-bit input nibble and a 4-bit control nibble.
// R4: A sequencer runs only while its enable bit is set.
// R5: Software programs steps, trigger and mask before enabling a sequencer.
// R6: The same input may appear in several steps and is sampled each time.
// R7: Per-step interrupt enables are independent; any step may raise the raw interrupt.
// R8: The sequence stops after the step carrying the end bit.
// R9: Each FIFO is circular, read through one address, read pops oldest.
// R10: Status register shows head, tail, full and empty per sequencer.
// R11: Overflow and underflow are recorded in separate status registers.
// R12: Control logic runs on the converter clock derived by fixed division.
// R13: Raw events reach the interrupt output only when masked in.
// R14: One register shows raw status, another only masked-in status.
// R15: Writing one to masked status clears that interrupt; zero does nothing.
// R16: Concurrent triggers are served by priority value, 0 highest, 3 lowest.
// R17: Software gives every active sequencer a distinct priority.
// R18: Each sequencer picks its trigger; processor and always triggers exist.
// R19: Writing the initiate bit starts a sequencer set to processor trigger.
// R20: Always trigger retriggers continuously and can starve lower priorities.
// R21: Sequencing sustains 500 thousand samples per second.
// R22: Hardware averaging combines up to 64 conversions into one result.
// R23: Averaging off after reset; one shared setting for every input.
// R24: Differential step uses pair number n, sampling inputs 2n and 2n+1.
// R25: Priority resets to sequencer 0 highest through sequencer 3 lowest.
// R26: Full FIFO drops result and flags overflow; empty read flags underflow; W1C.
module assc_top
    import assc_pkg::*;
#(
    parameter int PACE = PACE_CYC
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [3:0] SEL_I,
    input wire logic [7:0] ADR_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic [NTRIG-1:0] TRIG_I,
    output assc_conv_req_t CONV_REQ_O,
    input wire logic CONV_DONE_I,
    input wire logic [RES_W-1:0] CONV_DATA_I,
    output logic [NSEQ-1:0] IRQ_O
);
    // ==========================================
    // Elaboration check
    if (PACE < 1 || PACE > 63) begin : g_chk
        $error("PACE must lie in 1..63");
    end

    assc_state_t q, n;
    logic [3:0] hit, gclr, tevt, tsel, nib_sel, nib_ctl;
    logic gv, req, last_smp, pushv, pfull, prio_ok;
    logic [1:0] gi, bp, s;
    logic [31:0] wm, rdv;
    logic [15:0] sum;

    // ==========================================
    // Outputs straight from the state register
    assign DAT_O = q.dat;
    assign ACK_O = q.ack;
    assign CONV_REQ_O = q.conv;
    assign IRQ_O = q.ris & q.im; // R13

    // Merge of old value and bus data under byte enables
    function automatic logic [31:0] bw(input logic [31:0] o, input logic [31:0] d,
                                       input logic [31:0] m);
        return (o & ~m) | (d & m);
    endfunction

    // ==========================================
    // Next-state logic
    always_comb begin
        n = q;
        hit = '0;
        gclr = '0;
        tsel = '0;
        gv = 1'b0;
        gi = '0;
        bp = '0;
        rdv = '0;
        pushv = 1'b0;
        pfull = 1'b0;
        sum = '0;
        last_smp = 1'b0;
        s = ADR_I[6:5];
        req = CYC_I & STB_I & ~q.ack;
        wm = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
        nib_sel = q.mux[q.cur][4*q.step +: 4]; // R3
        nib_ctl = q.ctl[q.cur][4*q.step +: 4]; // R3
        n.ack = req;
        n.dat = '0;
        n.conv.start = 1'b0;
        if (q.pace != 6'h00) begin
            n.pace = q.pace - 6'h01;
        end

        // Trigger pins: a level counts once the second and third stage agree
        n.ts1 = TRIG_I;
        n.ts2 = q.ts1;
        n.ts3 = q.ts2;
        for (int k = 0; k < NTRIG; k++) begin
            if (q.ts2[k] == q.ts3[k]) begin
                n.tstab[k] = q.ts2[k];
            end
        end
        tevt = q.ts2 & q.ts3 & ~q.tstab;

        // Bus access; clears happen before hardware sets so a set wins
        if (req) begin
            if (ADR_I[7]) begin
                if (ADR_I[4:0] == SUB_MUX) begin
                    rdv = q.mux[s];
                    if (WE_I) begin
                        n.mux[s] = bw(q.mux[s], DAT_I, wm) & step_mask(s); // R1
                    end
                end else if (ADR_I[4:0] == SUB_CTL) begin
                    rdv = q.ctl[s];
                    if (WE_I) begin
                        n.ctl[s] = bw(q.ctl[s], DAT_I, wm) & step_mask(s);
                    end
                end else if (ADR_I[4:0] == SUB_FIFO) begin
                    if (!WE_I) begin
                        if (q.cnt[s] == 4'h0) begin
                            n.udf[s] = 1'b1; // R26
                        end else begin
                            rdv = {22'h0, q.fifo[s][q.head[s]]}; // R2
                            n.head[s] = ptr_inc(q.head[s], s); // R9
                            n.cnt[s] = q.cnt[s] - 4'h1;
                        end
                    end
                end else if (ADR_I[4:0] == SUB_FST) begin
                    rdv[3:0] = {1'b0, q.tail[s]}; // R10
                    rdv[7:4] = {1'b0, q.head[s]};
                    rdv[FST_EMPTY] = q.cnt[s] == 4'h0;
                    rdv[FST_FULL] = q.cnt[s] == 4'(seq_depth(s));
                end
            end else if (ADR_I == OFF_ACT) begin
                rdv[3:0] = q.act;
                if (WE_I) begin
                    n.act = 4'(bw({28'h0, q.act}, DAT_I, wm));
                end
            end else if (ADR_I == OFF_RIS) begin
                rdv[3:0] = q.ris; // R14
            end else if (ADR_I == OFF_IM) begin
                rdv[3:0] = q.im;
                if (WE_I) begin
                    n.im = 4'(bw({28'h0, q.im}, DAT_I, wm));
                end
            end else if (ADR_I == OFF_ISC) begin
                rdv[3:0] = q.ris & q.im; // R14
                if (WE_I) begin
                    n.ris = q.ris & ~(DAT_I[3:0] & wm[3:0]); // R15
                end
            end else if (ADR_I == OFF_OVF) begin
                rdv[3:0] = q.ovf; // R11
                if (WE_I) begin
                    n.ovf = q.ovf & ~(DAT_I[3:0] & wm[3:0]);
                end
            end else if (ADR_I == OFF_UDF) begin
                rdv[3:0] = q.udf; // R11
                if (WE_I) begin
                    n.udf = q.udf & ~(DAT_I[3:0] & wm[3:0]);
                end
            end else if (ADR_I == OFF_TRG) begin
                rdv[15:0] = q.trg;
                if (WE_I) begin
                    n.trg = 16'(bw({16'h0, q.trg}, DAT_I, wm)); // R18
                end
            end else if (ADR_I == OFF_PRI) begin
                rdv[15:0] = q.pri & 16'h3333;
                if (WE_I) begin
                    n.pri = 16'(bw({16'h0, q.pri}, DAT_I, wm)) & 16'h3333;
                end
            end else if (ADR_I == OFF_AVG) begin
                rdv[2:0] = q.avg;
                if (WE_I && SEL_I[0]) begin
                    n.avg = (DAT_I[2:0] > AVG_MAX) ? AVG_MAX : DAT_I[2:0]; // R22
                end
            end
            n.dat = WE_I ? 32'h0000_0000 : rdv;
        end

        // Trigger selection per sequencer
        for (int i = 0; i < NSEQ; i++) begin
            tsel = q.trg[4*i +: 4];
            if (tsel == TRG_ALWAYS) begin
                hit[i] = 1'b1; // R20
            end else if (tsel == TRG_PROC) begin
                hit[i] = req & WE_I & SEL_I[0] & (ADR_I == OFF_PSI) & DAT_I[i]; // R19
            end else if (tsel <= 4'(NTRIG)) begin
                hit[i] = tevt[2'(tsel - 4'h1)]; // R18
            end
        end

        // Lowest priority value wins; lower index breaks a tie
        for (int i = 0; i < NSEQ; i++) begin
            if (q.pend[i] && (!gv || q.pri[4*i +: 2] < bp)) begin
                gv = 1'b1; // R16
                gi = 2'(i);
                bp = q.pri[4*i +: 2];
            end
        end

        // Single converter shared by all sequencers
        case (q.ph)
            PH_IDLE: begin
                if (gv) begin
                    n.cur = gi;
                    n.step = 3'h0;
                    n.nsmp = 6'h00;
                    n.acc = 16'h0000;
                    n.ph = PH_ISSUE;
                    gclr[gi] = 1'b1;
                end
            end
            PH_ISSUE: begin
                if (!q.act[q.cur]) begin
                    n.ph = PH_IDLE; // R4
                end else if (q.pace == 6'h00) begin
                    // Spacing keeps the converter at one sample per slot
                    n.conv.start = 1'b1; // R21
                    n.conv.diff = nib_ctl[CB_DIFF];
                    n.conv.temp = nib_ctl[CB_TEMP];
                    n.conv.sel = nib_ctl[CB_DIFF] ? {nib_sel[1:0], 1'b0} : nib_sel[2:0]; // R24
                    n.pace = 6'(PACE - 1);
                    n.ph = PH_WAIT;
                end
            end
            PH_WAIT: begin
                if (CONV_DONE_I) begin
                    sum = q.acc + {6'h00, CONV_DATA_I};
                    last_smp = {1'b0, q.nsmp} == (7'h01 << q.avg) - 7'h01; // R23
                    n.acc = sum;
                    n.nsmp = q.nsmp + 6'h01;
                    n.ph = PH_ISSUE;
                    if (last_smp) begin
                        pushv = 1'b1;
                        n.acc = 16'h0000;
                        n.nsmp = 6'h00;
                        if (nib_ctl[CB_IE]) begin
                            n.ris[q.cur] = 1'b1; // R7
                        end
                        if (nib_ctl[CB_END] || int'(q.step) == seq_depth(q.cur) - 1) begin
                            n.ph = PH_IDLE; // R8
                        end else begin
                            n.step = q.step + 3'h1; // R6
                        end
                    end
                end
            end
            default: n.ph = PH_IDLE;
        endcase

        // Result into FIFO; a full FIFO keeps its contents
        if (pushv) begin
            pfull = q.cnt[q.cur] == 4'(seq_depth(q.cur)); // R1
            if (pfull) begin
                n.ovf[q.cur] = 1'b1; // R26
            end else begin
                n.fifo[q.cur][q.tail[q.cur]] = 10'(sum >> q.avg); // R22
                n.tail[q.cur] = ptr_inc(q.tail[q.cur], q.cur); // R9
                n.cnt[q.cur] = n.cnt[q.cur] + 4'h1;
            end
        end
        n.pend = ((q.pend & ~gclr) | hit) & n.act; // R4
    end

    // ==========================================
    // State register
    always_ff @(posedge CLK_I or posedge RESET_I) begin // R12
        if (RESET_I) begin
            q <= '0; // R23
            q.pri <= PRIO_RST; // R25
        end else begin
            q <= n;
        end
    end

    // ==========================================
    // Checks
    always_comb begin
        prio_ok = 1'b1;
        for (int j = 0; j < NSEQ; j++) begin
            if (q.pend[j] && q.pri[4*j +: 2] < q.pri[4*gi +: 2]) begin
                prio_ok = 1'b0;
            end
        end
    end

    default clocking dcb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    a_enable_gate: assert property ((q.ph == PH_IDLE && gv) |-> q.act[gi]) // R4
        else $error("disabled sequencer granted");
    a_prio_order: assert property ((q.ph == PH_IDLE && gv) |-> prio_ok) // R16
        else $error("lower priority sequencer granted");
    a_end_stop: assert property ((pushv && nib_ctl[CB_END]) |=> q.ph == PH_IDLE) // R8
        else $error("sequence ran past end step");
    a_full_drop: assert property ((pushv && pfull) |=> q.ovf[$past(q.cur)]) // R26
        else $error("overflow not flagged");
    a_empty_read: assert property ((req && !WE_I && ADR_I[7] && ADR_I[4:0] == SUB_FIFO // R11
        && q.cnt[s] == 4'h0) |=> q.udf[$past(s)] && ACK_O)
        else $error("underflow not flagged");
    a_irq_clear: assert property ((req && WE_I && ADR_I == OFF_ISC && SEL_I[0] && DAT_I[0] // R15
        && !(pushv && q.cur == 2'h0)) |=> !q.ris[0])
        else $error("interrupt not cleared");
    a_mask_gate: assert property ((q.ris[1] && !q.im[1]) |-> !IRQ_O[1]) // R13
        else $error("masked interrupt escaped");
    a_pace_gap: assert property (CONV_REQ_O.start |-> $past(q.pace) == 6'h00 // R21
        && q.ph == PH_WAIT)
        else $error("conversion started early");
    a_avg_bypass: assert property ((q.ph == PH_WAIT && CONV_DONE_I && q.avg == 3'h0) // R23
        |-> pushv)
        else $error("unaveraged result not pushed");
    a_diff_even: assert property ((CONV_REQ_O.start && CONV_REQ_O.diff) // R24
        |-> !CONV_REQ_O.sel[0])
        else $error("differential pair not even");
    // FIFO bookkeeping, step interrupts and grant hand-over; a slip here loses results silently
    a_fifo_bound: assert property (q.cnt[q.cur] <= 4'(seq_depth(q.cur))) // R1
        else $error("fifo count beyond depth");
    a_fifo_push: assert property ((pushv && !pfull) |=> q.cnt[$past(q.cur)] != 4'h0) // R9
        else $error("pushed result not counted");
    a_read_pop: assert property ((req && !WE_I && ADR_I[7] && ADR_I[4:0] == SUB_FIFO // R9
        && q.cnt[s] != 4'h0 && !(pushv && q.cur == s))
        |=> q.cnt[$past(s)] == $past(q.cnt[s]) - 4'h1)
        else $error("fifo read did not pop");
    a_raw_set: assert property ((pushv && nib_ctl[CB_IE]) |=> q.ris[$past(q.cur)]) // R7
        else $error("step interrupt not raised");
    a_grant_next: assert property ((q.ph == PH_IDLE && gv) |=> q.ph == PH_ISSUE // R16
        && q.cur == $past(gi))
        else $error("grant not taken up");

    c_seq_end: cover property (pushv && nib_ctl[CB_END]);
    c_overflow: cover property (pushv && pfull);
    c_contend: cover property (q.ph == PH_IDLE && gv && $countones(q.pend) > 1);
    c_average: cover property (pushv && q.avg != 3'h0);
    c_diff_pair: cover property (CONV_REQ_O.start && CONV_REQ_O.diff);
endmodule

//--- test/assc_conv_model.sv
// Behavioural converter core that answers each start pulse with one result
`timescale 1ns/1ps
module assc_conv_model
    import assc_pkg::*;
(
    input wire logic clk_i,
    input wire logic slow_i,
    input wire assc_conv_req_t req_i,
    output logic done_o,
    output logic [RES_W-1:0] data_o
);
    // ==========================================
    // Conversion
    // Result encodes the request so the bench can tell the steps apart
    initial begin
        done_o = 1'b0;
        data_o = '0;
        forever begin
            @(posedge clk_i);
            if (req_i.start === 1'b1) begin
                repeat (slow_i ? 9 : 1) @(posedge clk_i);
                done_o <= 1'b1;
                data_o <= {req_i.temp, req_i.diff, 5'h00, req_i.sel};
                @(posedge clk_i);
                done_o <= 1'b0;
                // Released data shows the inverse, never a stale copy
                data_o <= ~data_o;
            end
        end
    end
endmodule

//--- test/adc_sample_sequencer_control_tb.sv
// Self-checking bench for the sample sequencer control block
`timescale 1ns/1ps
module adc_sample_sequencer_control_tb
    import assc_pkg::*;
;
    // ==========================================
    // Signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'hF;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rd;
    logic [31:0] dat;
    logic [31:0] v;
    logic [3:0] trig = 4'h0;
    logic [3:0] irq;
    logic [3:0] mux [8];
    logic [9:0] cdata;
    logic slow = 1'b0;
    logic done;
    logic ack;
    logic [31:0] seed = 32'h0000_0040;
    assc_conv_req_t creq;
    logic [2:0] sels [$];
    int fail_count = 0;
    int n_compared = 0;
    int nstart = 0;

    always #20 clk = ~clk;

    // ==========================================
    // Design and converter model
    assc_top #(.PACE(2)) DUT (
        .CLK_I(clk), .RESET_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .SEL_I(sel), .ADR_I(adr), .DAT_I(wdat), .DAT_O(dat), .ACK_O(ack),
        .TRIG_I(trig), .CONV_REQ_O(creq), .CONV_DONE_I(done),
        .CONV_DATA_I(cdata), .IRQ_O(irq)
    );
    assc_conv_model conv (.clk_i(clk), .slow_i(slow), .req_i(creq), .done_o(done),
        .data_o(cdata));

    // Count starts and log the inputs in the order they were asked for
    always @(posedge clk) begin
        if (creq.start === 1'b1) begin
            nstart++;
            sels.push_back(creq.sel);
        end
    end

    // ==========================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] res_word(input logic [2:0] s, input logic d);
        return {22'h00_0000, 1'b0, d, 5'h00, s};
    endfunction
    function automatic logic [7:0] sq(input logic [1:0] n, input logic [4:0] sub);
        return {1'b1, n, sub};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle: hold until ack is sampled, then release for a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // Only the watchdog ends a wait that never sees ack
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    // Status polling bounded, so a stuck sequencer cannot hang the run
    task automatic poll(input logic [7:0] a, input logic [31:0] e);
        int n;
        n = 0;
        do begin
            wb(1'b0, a, 32'h0000_0000);
            n++;
        end while (rd !== e && n < 200);
        chk(rd, e);
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================
    // Watchdog, far beyond the thousand or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("[ERR] %0t timeout", $time);
        final_report();
    end

    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(OFF_PRI, 32'h0000_3210);
        rdchk(OFF_AVG, 32'h0000_0000);
        rdchk(OFF_ACT, 32'h0000_0000);
        rdchk(8'h3C, 32'h0000_0000);
        // Random inputs, a repeated input and a differential pair on step 2
        for (int k = 0; k < 8; k++) mux[k] = 4'(rnd() & 7);
        mux[1] = mux[0];
        mux[2] = mux[2] & 4'h3;
        v = 32'h0000_0000;
        for (int k = 0; k < 8; k++) v[4*k+:4] = mux[k];
        slow <= 1'(rnd());
        wr(sq(0, SUB_MUX), v);
        // End on step 4, temperature on step 3; later steps must never run
        wr(sq(0, SUB_CTL), 32'h6666_8140);
        rdchk(sq(0, SUB_CTL), 32'h6666_8140);
        nstart = 0;
        wr(OFF_ACT, 32'h0000_0001);
        wr(OFF_PSI, 32'h0000_0001);
        poll(sq(0, SUB_FST), 32'h0000_0005);
        repeat (30) @(posedge clk);
        chk(nstart, 5);
        chk(32'(irq), 0);
        rdchk(OFF_RIS, 32'h0000_0001);
        rdchk(OFF_ISC, 32'h0000_0000);
        wr(OFF_IM, 32'h0000_0001);
        chk(32'(irq), 1);
        wr(OFF_ISC, 32'h0000_0000);
        rdchk(OFF_ISC, 32'h0000_0001);
        wr(OFF_ISC, 32'h0000_0001);
        rdchk(OFF_RIS, 32'h0000_0000);
        // A write with no byte lane enabled must leave the mask alone
        sel <= 4'h0;
        wr(OFF_IM, 32'h0000_0000);
        sel <= 4'hF;
        rdchk(OFF_IM, 32'h0000_0001);
        for (int k = 0; k < 5; k++) begin
            v = (k == 2) ? res_word({mux[2][1:0], 1'b0}, 1'b1) : res_word(mux[k][2:0], 1'b0);
            if (k == 3) v[9] = 1'b1;
            rdchk(sq(0, SUB_FIFO), v);
        end
        rdchk(sq(0, SUB_FST), 32'h0000_0155);
        rdchk(sq(0, SUB_FIFO), 32'h0000_0000);
        rdchk(OFF_UDF, 32'h0000_0001);
        wr(OFF_UDF, 32'h0000_0001);
        rdchk(OFF_UDF, 32'h0000_0000);
        // Two sequencers pending at once, the higher index ranked first
        wr(OFF_PRI, 32'h0000_2031);
        wr(sq(1, SUB_MUX), 32'hFFFF_0001);
        rdchk(sq(1, SUB_MUX), 32'h0000_0001);
        wr(sq(1, SUB_CTL), 32'h0000_0002);
        wr(sq(2, SUB_MUX), 32'h0000_0002);
        wr(sq(2, SUB_CTL), 32'h0000_0002);
        wr(OFF_ACT, 32'h0000_0006);
        sels.delete();
        wr(OFF_PSI, 32'h0000_0006);
        poll(sq(1, SUB_FST), 32'h0000_0001);
        chk(32'(sels[0]), 2);
        chk(32'(sels[1]), 1);
        // Initiate on a disabled sequencer does nothing
        nstart = 0;
        wr(OFF_PSI, 32'h0000_0008);
        repeat (20) @(posedge clk);
        chk(nstart, 0);
        // Pin trigger on sequencer one
        wr(OFF_TRG, 32'h0000_0010);
        trig <= 4'h1;
        poll(sq(1, SUB_FST), 32'h0000_0002);
        // Averaging of four, then a second result into a one-deep FIFO
        wr(OFF_AVG, 32'h0000_0002);
        wr(sq(3, SUB_MUX), 32'h0000_0003);
        wr(sq(3, SUB_CTL), 32'h0000_0002);
        wr(OFF_ACT, 32'h0000_0008);
        nstart = 0;
        wr(OFF_PSI, 32'h0000_0008);
        poll(sq(3, SUB_FST), 32'h0000_1000);
        chk(nstart, 4);
        wr(OFF_PSI, 32'h0000_0008);
        poll(OFF_OVF, 32'h0000_0008);
        chk(nstart, 8);
        rdchk(sq(3, SUB_FIFO), res_word(3'h3, 1'b0));
        wr(OFF_OVF, 32'h0000_0008);
        rdchk(OFF_OVF, 32'h0000_0000);
        // Always trigger keeps converting until the enable is dropped
        wr(OFF_AVG, 32'h0000_0000);
        wr(OFF_TRG, 32'h0000_F000);
        nstart = 0;
        // Long enough for more than twenty starts with the slow converter too
        repeat (300) @(posedge clk);
        chk(32'(nstart > 20), 1);
        wr(OFF_ACT, 32'h0000_0000);
        repeat (20) @(posedge clk);
        nstart = 0;
        repeat (40) @(posedge clk);
        chk(nstart, 0);
        final_report();
    end
endmodule
